// ### rtl/synth_cfg_map.svh
// Bit positions, field widths and timing figures of the configuration latches
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// ----------------------------------------------------------------------
// Serial word
// ----------------------------------------------------------------------
`define WORD_BITS          24
`define SEL_LO_BIT         0
`define SEL_HI_BIT         1
`define SEL_CONFIG         2'h0
`define SEL_REFERENCE      2'h1
`define SEL_FEEDBACK       2'h2
`define SEL_TEST           2'h3

// ----------------------------------------------------------------------
// Configuration latch fields
// ----------------------------------------------------------------------
`define CORE_POWER_LSB     2
`define COUNTER_RESET_BIT  4
`define MUX_SELECT_LSB     5
`define POLARITY_BIT       8
`define PUMP_TRISTATE_BIT  9
`define CFG_GAIN_BIT       10
`define MUTE_LOCK_BIT      11
`define OUTPUT_POWER_LSB   12
`define CURRENT_A_LSB      14
`define CURRENT_B_LSB      17
`define PD_REQUEST_BIT     20
`define PD_SYNC_MODE_BIT   21
`define PRESCALER_LSB      22

// ----------------------------------------------------------------------
// Feedback divider latch fields
// ----------------------------------------------------------------------
`define SWALLOW_LSB        2
`define SWALLOW_BITS       5
`define MAIN_LSB           8
`define MAIN_BITS          13
`define FB_GAIN_BIT        21
`define HALVING_BIT        22
`define PRESCALER_SRC_BIT  23
`define MAIN_COUNT_MIN     13'h0003

// ----------------------------------------------------------------------
// Reference divider latch fields
// ----------------------------------------------------------------------
`define REF_COUNT_LSB      2
`define REF_COUNT_BITS     14
`define BACKLASH_LSB       16
`define LOCK_PRECISION_BIT 18
`define TEST_ENABLE_BIT    19
`define BAND_CLOCK_LSB     20

// ----------------------------------------------------------------------
// Lock detect and power-down timing, and the feedback division width
// ----------------------------------------------------------------------
`define PHASE_WINDOW_NS    15
`define LOCK_CYCLES_FINE   3'h5
`define LOCK_CYCLES_COARSE 3'h3
`define SYNC_PD_REF_EDGES  2'h2
`define FEEDBACK_BITS      18

`endif

// ### rtl/synth_cfg_pkg.sv
// Types shared by the synthesizer configuration latch logic
package synth_cfg_pkg;

  typedef enum logic [2:0] {
    PD_RUN   = 3'h1,
    PD_ARMED = 3'h2,
    PD_DOWN  = 3'h4
  } pd_state_e;

  typedef struct packed {
    logic [2:0]  pump_current;
    logic        pump_gain_select;
    logic        pump_tristate;
    logic        detector_polarity;
    logic        mute_until_lock;
    logic [2:0]  mux_select;
    logic [1:0]  output_power;
    logic [1:0]  core_power;
    logic [1:0]  prescaler_select;
    logic [4:0]  swallow_count;
    logic [12:0] main_count;
    logic        main_count_legal;
    logic        output_halving_enable;
    logic        prescaler_source_select;
    logic [13:0] reference_count;
    logic [1:0]  backlash_width;
    logic        lock_precision_select;
    logic        factory_test_enable;
    logic [1:0]  band_clock_div;
  } settings_s;

endpackage : synth_cfg_pkg

// ### rtl/synth_config_latches.sv
// Serial-loaded configuration latches of an integer-N synthesizer
`timescale 1ns/1ns
`include "synth_cfg_map.svh"

module synth_config_latches (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    serial_clk,
  input  wire logic                    serial_data,
  input  wire logic                    load_strobe,
  input  wire logic                    chip_enable,
  input  wire logic                    ref_div_out,
  input  wire logic                    phase_ok,
  output synth_cfg_pkg::settings_s     settings,
  output logic [`FEEDBACK_BITS-1:0]    feedback_division,
  output logic                         powered_down,
  output logic                         counters_in_load,
  output logic                         pump_tristated,
  output logic                         rf_output_enable,
  output logic                         ref_buffer_enable,
  output logic                         lock_detect
);

  // --------------------------------------------------------------------
  // Serial shift register on the link clock
  // --------------------------------------------------------------------
  logic [`WORD_BITS-1:0] shift_word;

  // Runs regardless of power-down so words still load
  always_ff @(posedge serial_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_word <= '0;
    else
      shift_word <= {shift_word[`WORD_BITS-2:0], serial_data};
  end

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic [3:0] pins_meta;
  logic [3:0] pins_sync;
  logic       strobe_d;
  logic       ref_d;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_meta <= 4'h0;
      pins_sync <= 4'h0;
      strobe_d  <= 1'b0;
      ref_d     <= 1'b0;
    end
    else
    begin
      pins_meta <= {phase_ok, ref_div_out, chip_enable, load_strobe};
      pins_sync <= pins_meta;
      strobe_d  <= pins_sync[0];
      ref_d     <= pins_sync[2];
    end
  end

  wire strobe_s   = pins_sync[0];
  wire ce_s       = pins_sync[1];
  wire ref_s      = pins_sync[2];
  wire phase_ok_s = pins_sync[3];
  // Shift word is quiet while the strobe is high, so it is safe to take
  wire strobe_rise = strobe_s & ~strobe_d;
  wire ref_rise    = ref_s & ~ref_d;

  // --------------------------------------------------------------------
  // Latch decode
  // --------------------------------------------------------------------
  function automatic logic sel_is(input logic [`WORD_BITS-1:0] w,
                                  input logic [1:0] code);
    sel_is = ({w[`SEL_HI_BIT], w[`SEL_LO_BIT]} == code);
  endfunction : sel_is

  wire load_cfg = strobe_rise & sel_is(shift_word, `SEL_CONFIG);
  wire load_fb  = strobe_rise & sel_is(shift_word, `SEL_FEEDBACK);
  wire load_ref = strobe_rise & sel_is(shift_word, `SEL_REFERENCE);

  logic [`WORD_BITS-1:0] cfg_latch;
  logic [`WORD_BITS-1:0] fb_latch;
  logic [`WORD_BITS-1:0] ref_latch;
  logic                  pump_gain;

  // Test latch writes are dropped; factory test bit is only reported
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_latch <= '0;
      fb_latch  <= '0;
      ref_latch <= '0;
      pump_gain <= 1'b0;
    end
    else
    begin
      if (load_cfg)
        cfg_latch <= shift_word;
      if (load_fb)
        fb_latch <= shift_word;
      if (load_ref)
        ref_latch <= shift_word;
      if (load_cfg)
        pump_gain <= shift_word[`CFG_GAIN_BIT];
      else if (load_fb)
        pump_gain <= shift_word[`FB_GAIN_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Power-down control
  // --------------------------------------------------------------------
  synth_cfg_pkg::pd_state_e pd_state;
  synth_cfg_pkg::pd_state_e next_pd_state;
  logic [1:0]               ref_edges;

  wire req_in  = shift_word[`PD_REQUEST_BIT];
  wire mode_in = shift_word[`PD_SYNC_MODE_BIT];

  always_comb
  begin
    next_pd_state = pd_state;
    case (pd_state)
      synth_cfg_pkg::PD_RUN:
        if (load_cfg && req_in && !mode_in)
          next_pd_state = synth_cfg_pkg::PD_DOWN;
        else if (load_cfg && req_in && mode_in)
          next_pd_state = synth_cfg_pkg::PD_ARMED;
      synth_cfg_pkg::PD_ARMED:
        if (load_cfg && !req_in)
          next_pd_state = synth_cfg_pkg::PD_RUN;
        else if (load_cfg && !mode_in)
          next_pd_state = synth_cfg_pkg::PD_DOWN;
        else if (ref_rise && ref_edges == `SYNC_PD_REF_EDGES - 2'h1)
          next_pd_state = synth_cfg_pkg::PD_DOWN;
      synth_cfg_pkg::PD_DOWN:
        if (load_cfg && !req_in)
          next_pd_state = synth_cfg_pkg::PD_RUN;
      default:
        next_pd_state = synth_cfg_pkg::PD_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_state  <= synth_cfg_pkg::PD_RUN;
      ref_edges <= 2'h0;
    end
    else
    begin
      pd_state <= next_pd_state;
      // Edges count only from the latest configuration strobe while armed
      if (pd_state != synth_cfg_pkg::PD_ARMED || load_cfg)
        ref_edges <= 2'h0;
      else if (ref_rise)
        ref_edges <= ref_edges + 2'h1;
    end
  end

  assign powered_down = ~ce_s | (pd_state == synth_cfg_pkg::PD_DOWN);

  // --------------------------------------------------------------------
  // Lock detect
  // --------------------------------------------------------------------
  logic [2:0] good_run;
  logic       lock_reg;
  wire  [2:0] lock_need = ref_latch[`LOCK_PRECISION_BIT] ?
                          `LOCK_CYCLES_FINE : `LOCK_CYCLES_COARSE;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_run <= 3'h0;
      lock_reg <= 1'b0;
    end
    else if (powered_down)
    begin
      good_run <= 3'h0;
      lock_reg <= 1'b0;
    end
    else if (ref_rise)
    begin
      if (!phase_ok_s)
        good_run <= 3'h0;
      else if (good_run < lock_need)
        good_run <= good_run + 3'h1;
      lock_reg <= phase_ok_s && (good_run + 3'h1 >= lock_need);
    end
  end

  assign lock_detect = lock_reg & ~powered_down;

  // --------------------------------------------------------------------
  // Side effects and decoded settings
  // --------------------------------------------------------------------
  wire mute_on = cfg_latch[`MUTE_LOCK_BIT];

  assign counters_in_load  = powered_down
                           | cfg_latch[`COUNTER_RESET_BIT];
  assign pump_tristated    = powered_down
                           | cfg_latch[`PUMP_TRISTATE_BIT];
  assign ref_buffer_enable = ~powered_down;
  assign rf_output_enable  = ~powered_down
                           & (~mute_on | lock_detect);

  wire [5:0] presc_val = (cfg_latch[`PRESCALER_LSB+1]) ? 6'h20 :
                         (cfg_latch[`PRESCALER_LSB] ? 6'h10 : 6'h08);
  wire [12:0] main_w   = fb_latch[`MAIN_LSB +: `MAIN_BITS];
  wire [4:0]  swal_w   = fb_latch[`SWALLOW_LSB +: `SWALLOW_BITS];
  // Operands widened first so the product keeps all its bits
  wire [`FEEDBACK_BITS-1:0] next_division =
    `FEEDBACK_BITS'(presc_val) * `FEEDBACK_BITS'(main_w)
    + `FEEDBACK_BITS'(swal_w);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settings          <= '0;
      feedback_division <= '0;
    end
    else
    begin
      feedback_division <= next_division;
      settings.pump_current <= pump_gain ?
        cfg_latch[`CURRENT_B_LSB +: 3] :
        cfg_latch[`CURRENT_A_LSB +: 3];
      settings.pump_gain_select  <= pump_gain;
      settings.pump_tristate     <= cfg_latch[`PUMP_TRISTATE_BIT];
      settings.detector_polarity <= cfg_latch[`POLARITY_BIT];
      settings.mute_until_lock   <= mute_on;
      settings.mux_select        <= cfg_latch[`MUX_SELECT_LSB +: 3];
      settings.output_power      <= cfg_latch[`OUTPUT_POWER_LSB +: 2];
      settings.core_power        <= cfg_latch[`CORE_POWER_LSB +: 2];
      settings.prescaler_select  <= cfg_latch[`PRESCALER_LSB +: 2];
      settings.swallow_count     <= swal_w;
      settings.main_count        <= main_w;
      settings.main_count_legal  <= (main_w >= `MAIN_COUNT_MIN);
      settings.output_halving_enable   <= fb_latch[`HALVING_BIT];
      settings.prescaler_source_select <= fb_latch[`PRESCALER_SRC_BIT];
      settings.reference_count   <=
        ref_latch[`REF_COUNT_LSB +: `REF_COUNT_BITS];
      settings.backlash_width    <= ref_latch[`BACKLASH_LSB +: 2];
      settings.lock_precision_select <= ref_latch[`LOCK_PRECISION_BIT];
      settings.factory_test_enable   <= ref_latch[`TEST_ENABLE_BIT];
      settings.band_clock_div    <= ref_latch[`BAND_CLOCK_LSB +: 2];
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  cfg_load_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg |=> cfg_latch == $past(shift_word))
    else $error("configuration latch missed its word");

  fb_load_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    strobe_rise && shift_word[1:0] == 2'h2 |=> fb_latch == $past(shift_word))
    else $error("feedback latch missed its word");

  ref_load_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    strobe_rise && shift_word[1:0] == 2'h1 |=> ##1
    settings.reference_count == $past(shift_word[15:2], 2))
    else $error("reference count not taken");

  async_pd_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg && req_in && !mode_in |=> powered_down)
    else $error("immediate power-down did not occur");

  sync_pd_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $past(pd_state) == synth_cfg_pkg::PD_ARMED && !$past(load_cfg)
    && pd_state == synth_cfg_pkg::PD_DOWN |-> $past(ref_rise)
    && $past(ref_edges) == 2'h1)
    else $error("synchronous power-down came too early");

  ce_off_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(ce_s) |-> powered_down && !rf_output_enable)
    else $error("chip enable low did not disable");

  pd_effect_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    powered_down |-> counters_in_load && pump_tristated
    && !ref_buffer_enable && !lock_detect)
    else $error("power-down side effects missing");

  gain_last_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_fb |=> ##1 settings.pump_gain_select == $past(shift_word[21], 2))
    else $error("gain bit does not follow latest write");

  mute_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mute_on && !lock_detect |-> !rf_output_enable)
    else $error("RF enabled before lock while muted");

  lock_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(lock_reg) |-> good_run >= lock_need - 3'h1)
    else $error("lock declared too soon");

  current_pick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg && shift_word[`CFG_GAIN_BIT] |=> ##1
    settings.pump_current == $past(shift_word[`CURRENT_B_LSB +: 3], 2))
    else $error("gain bit did not pick current setting two");

  tristate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg && shift_word[`PUMP_TRISTATE_BIT] |=> pump_tristated)
    else $error("three-state bit did not tristate the pump");

  cnt_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg && shift_word[`COUNTER_RESET_BIT] |=> counters_in_load)
    else $error("counter reset bit did not hold the counters");

  polarity_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_cfg |=> ##1
    settings.detector_polarity == $past(shift_word[`POLARITY_BIT], 2))
    else $error("detector polarity not taken");

  main_legal_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_fb |=> ##1 settings.main_count_legal
    == ($past(shift_word[`MAIN_LSB +: `MAIN_BITS], 2) >= `MAIN_COUNT_MIN))
    else $error("main count range flag wrong");

  halving_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_fb |=> ##1
    settings.output_halving_enable == $past(shift_word[`HALVING_BIT], 2)
    && settings.prescaler_source_select
    == $past(shift_word[`PRESCALER_SRC_BIT], 2))
    else $error("output halving bits not taken");

  async_pd_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    load_cfg && req_in && !mode_in ##1 powered_down);
  sync_pd_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pd_state == synth_cfg_pkg::PD_ARMED ##[1:400]
    pd_state == synth_cfg_pkg::PD_DOWN);
  lock_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(lock_detect));
  fb_c: cover property (@(posedge clk_sys) disable iff (!rst_n) load_fb);
  test_word_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    strobe_rise && sel_is(shift_word, `SEL_TEST));

endmodule : synth_config_latches

// ### verif/serial_host_model.sv
// Host-side writer for the three-wire configuration port
`timescale 1ns/1ns
module serial_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial
  begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ----------------------------------------------------------------------
  // One word per frame
  // ----------------------------------------------------------------------
  // Link clock runs only inside a frame, 12 ns period
  task automatic send_word(input logic [23:0] word);
    int i;
    for (i = 23; i >= 0; i--)
    begin
      serial_data = word[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    // Data no longer valid, so show the inverse of the last bit
    serial_data = ~word[0];
    #20 load_strobe = 1'b1;
    // No link edge within 4 system cycles of the strobe rising
    #240 load_strobe = 1'b0;
    #160;
  endtask : send_word
endmodule : serial_host_model

// ### verif/synth_config_latches_tb_top.sv
// Self-checking bench for the synthesizer configuration latches
`timescale 1ns/1ns
`include "synth_cfg_map.svh"
module synth_config_latches_tb_top;
  logic                      clk_sys;
  logic                      rst_n;
  logic                      chip_enable;
  logic                      ref_div_out;
  logic                      phase_ok;
  wire                       serial_clk;
  wire                       serial_data;
  wire                       load_strobe;
  synth_cfg_pkg::settings_s  settings;
  logic [`FEEDBACK_BITS-1:0] feedback_division;
  logic                      powered_down;
  logic                      counters_in_load;
  logic                      pump_tristated;
  logic                      rf_output_enable;
  logic                      ref_buffer_enable;
  logic                      lock_detect;
  int                        fails;
  int                        comparisons;

  localparam logic [23:0] CFG_BASE = (24'h5 << `CURRENT_A_LSB)
    | (24'h2 << `CURRENT_B_LSB) | (24'h1 << `POLARITY_BIT)
    | (24'h1 << `MUTE_LOCK_BIT);
  localparam logic [23:0] GAIN    = 24'h1 << `CFG_GAIN_BIT;
  localparam logic [23:0] PD_REQ  = 24'h1 << `PD_REQUEST_BIT;
  localparam logic [23:0] PD_SYNC = 24'h1 << `PD_SYNC_MODE_BIT;

  serial_host_model host (
    .serial_clk  (serial_clk),
    .serial_data (serial_data),
    .load_strobe (load_strobe)
  );

  synth_config_latches DUT (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .serial_clk        (serial_clk),
    .serial_data       (serial_data),
    .load_strobe       (load_strobe),
    .chip_enable       (chip_enable),
    .ref_div_out       (ref_div_out),
    .phase_ok          (phase_ok),
    .settings          (settings),
    .feedback_division (feedback_division),
    .powered_down      (powered_down),
    .counters_in_load  (counters_in_load),
    .pump_tristated    (pump_tristated),
    .rf_output_enable  (rf_output_enable),
    .ref_buffer_enable (ref_buffer_enable),
    .lock_detect       (lock_detect)
  );

  always #20 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  function automatic logic [23:0] fb_word(input logic [4:0] sw,
    input logic [12:0] mn, input logic [23:0] extra);
    fb_word = (24'(sw) << `SWALLOW_LSB) | (24'(mn) << `MAIN_LSB)
      | extra | 24'(`SEL_FEEDBACK);
  endfunction : fb_word

  function automatic logic [23:0] ref_word(input logic [13:0] cnt,
    input logic prec);
    ref_word = (24'(cnt) << `REF_COUNT_LSB)
      | (24'(prec) << `LOCK_PRECISION_BIT) | 24'(`SEL_REFERENCE);
  endfunction : ref_word

  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chkv(input string what, input logic [17:0] exp,
    input logic [17:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chkv

  task automatic chk1(input string what, input logic exp, input logic got);
    chkv(what, {17'h0, exp}, {17'h0, got});
  endtask : chk1

  // Words go out, then outputs are sampled away from the clock edge
  task automatic put(input logic [23:0] w);
    host.send_word(w);
    @(negedge clk_sys);
  endtask : put

  task automatic wait_pd(input logic exp, input int limit);
    int n = 0;
    while (powered_down !== exp && n < limit)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk1("powered_down", exp, powered_down);
    if (powered_down !== exp)
      report_and_stop;
  endtask : wait_pd

  // Reference edge is seen 2-3 cycles late, so 4 high and 4 low is ample
  task automatic ref_pulse(input logic ok);
    @(posedge clk_sys);
    phase_ok    <= ok;
    ref_div_out <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ref_div_out <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : ref_pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic power_up_sequence;
    put(ref_word(14'h3fff, 1'b1));
    chkv("reference_count", 18'h3fff, 18'(settings.reference_count));
    chk1("precision", 1'b1, settings.lock_precision_select);
    put(CFG_BASE | GAIN);
    chk1("mute", 1'b1, settings.mute_until_lock);
    chk1("pump_gain", 1'b1, settings.pump_gain_select);
    chkv("pump_current", 18'h2, 18'(settings.pump_current));
    chk1("polarity", 1'b1, settings.detector_polarity);
    chk1("rf_enable", 1'b0, rf_output_enable);
    put(fb_word(5'h1f, 13'h1fff, 24'h3 << `HALVING_BIT));
    chkv("swallow", 18'h1f, 18'(settings.swallow_count));
    chkv("main", 18'h1fff, 18'(settings.main_count));
    chkv("division", 18'(8 * 8191 + 31), feedback_division);
    chk1("halving", 1'b1, settings.output_halving_enable);
    chk1("source", 1'b1, settings.prescaler_source_select);
    chk1("pump_gain", 1'b0, settings.pump_gain_select);
    chkv("pump_current", 18'h5, 18'(settings.pump_current));
  endtask : power_up_sequence

  task automatic gain_and_prescaler;
    put(CFG_BASE | GAIN | (24'h1 << `PRESCALER_LSB));
    chk1("pump_gain", 1'b1, settings.pump_gain_select);
    chkv("prescaler", 18'h1, 18'(settings.prescaler_select));
    put(fb_word(5'h3, 13'h3, 24'h1 << `FB_GAIN_BIT));
    chkv("division", 18'(16 * 3 + 3), feedback_division);
    chk1("main_legal", 1'b1, settings.main_count_legal);
    put(fb_word(5'h0, 13'h2, 24'h0));
    chk1("main_legal", 1'b0, settings.main_count_legal);
    chk1("pump_gain", 1'b0, settings.pump_gain_select);
    put(CFG_BASE | (24'h2 << `PRESCALER_LSB));
    chkv("division", 18'(32 * 2), feedback_division);
  endtask : gain_and_prescaler

  task automatic control_bits;
    put((CFG_BASE ^ (24'h1 << `POLARITY_BIT)) | (24'h1 << `PUMP_TRISTATE_BIT)
      | (24'h1 << `COUNTER_RESET_BIT) | (24'h5 << `MUX_SELECT_LSB)
      | (24'h2 << `OUTPUT_POWER_LSB) | (24'h1 << `CORE_POWER_LSB));
    chk1("pump_tristated", 1'b1, pump_tristated);
    chk1("tristate_bit", 1'b1, settings.pump_tristate);
    chk1("polarity", 1'b0, settings.detector_polarity);
    chkv("mux_select", 18'h5, 18'(settings.mux_select));
    chkv("output_power", 18'h2, 18'(settings.output_power));
    chkv("core_power", 18'h1, 18'(settings.core_power));
    chk1("counters_in_load", 1'b1, counters_in_load);
    chk1("powered_down", 1'b0, powered_down);
    put(CFG_BASE);
    chk1("pump_tristated", 1'b0, pump_tristated);
    chk1("counters_in_load", 1'b0, counters_in_load);
    put(24'hffffff);
    chkv("reference_count", 18'h3fff, 18'(settings.reference_count));
    chkv("main", 18'h2, 18'(settings.main_count));
    chk1("powered_down", 1'b0, powered_down);
    put(ref_word(14'h0002, 1'b0) | (24'h3 << `BACKLASH_LSB)
      | (24'h1 << `TEST_ENABLE_BIT) | (24'h2 << `BAND_CLOCK_LSB));
    chkv("reference_count", 18'h2, 18'(settings.reference_count));
    chkv("backlash", 18'h3, 18'(settings.backlash_width));
    chk1("test_enable", 1'b1, settings.factory_test_enable);
    chkv("band_clock", 18'h2, 18'(settings.band_clock_div));
    chk1("precision", 1'b0, settings.lock_precision_select);
  endtask : control_bits

  task automatic async_power_down;
    put(CFG_BASE | PD_REQ);
    chk1("powered_down", 1'b1, powered_down);
    chk1("counters_in_load", 1'b1, counters_in_load);
    chk1("pump_tristated", 1'b1, pump_tristated);
    chk1("rf_enable", 1'b0, rf_output_enable);
    chk1("ref_buffer", 1'b0, ref_buffer_enable);
    put(ref_word(14'h0001, 1'b1));
    chkv("reference_count", 18'h1, 18'(settings.reference_count));
    put(CFG_BASE);
    chk1("powered_down", 1'b0, powered_down);
  endtask : async_power_down

  task automatic sync_power_down;
    put(CFG_BASE | PD_REQ | PD_SYNC);
    chk1("powered_down", 1'b0, powered_down);
    ref_pulse(1'b1);
    chk1("powered_down", 1'b0, powered_down);
    ref_pulse(1'b1);
    chk1("powered_down", 1'b1, powered_down);
    put(CFG_BASE);
    wait_pd(1'b0, 4);
    @(posedge clk_sys);
    chip_enable <= 1'b0;
    wait_pd(1'b1, 4);
    chk1("counters_in_load", 1'b1, counters_in_load);
    @(posedge clk_sys);
    chip_enable <= 1'b1;
    wait_pd(1'b0, 4);
  endtask : sync_power_down

  task automatic lock_counting;
    ref_pulse(1'b0);
    repeat (4) ref_pulse(1'b1);
    chk1("lock", 1'b0, lock_detect);
    chk1("rf_enable", 1'b0, rf_output_enable);
    ref_pulse(1'b1);
    chk1("lock", 1'b1, lock_detect);
    chk1("rf_enable", 1'b1, rf_output_enable);
    ref_pulse(1'b0);
    put(ref_word(14'h0001, 1'b0));
    repeat (2) ref_pulse(1'b1);
    chk1("lock", 1'b0, lock_detect);
    ref_pulse(1'b1);
    chk1("lock", 1'b1, lock_detect);
    put(CFG_BASE | PD_REQ);
    chk1("lock", 1'b0, lock_detect);
  endtask : lock_counting

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    fails       = 0;
    comparisons = 0;
    clk_sys     = 1'b0;
    rst_n       = 1'b0;
    chip_enable = 1'b1;
    ref_div_out = 1'b0;
    phase_ok    = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    power_up_sequence;
    gain_and_prescaler;
    control_bits;
    async_power_down;
    sync_power_down;
    lock_counting;
    report_and_stop;
  end

  initial
  begin
    #2000000;
    fails++;
    $display("unexpected run_time expected %h seen %h", 1'b0, 1'b1);
    report_and_stop;
  end
endmodule : synth_config_latches_tb_top
